// ===== hw/haptic_map.vh
`ifndef HAPTIC_MAP_VH
`define HAPTIC_MAP_VH

// Register byte offsets
`define OFS_CTRL        8'h00
`define OFS_SAMPLE      8'h04
`define OFS_STATUS      8'h08
`define OFS_RAM_ADDR    8'h0C
`define OFS_RAM_DATA    8'h10
`define OFS_PLAY_RANGE  8'h14
`define OFS_FLAGS       8'h18

// Control register fields
`define CTRL_MODE_LSB   0
`define CTRL_OE_BIT     2
`define CTRL_RANGE_BIT  3
`define CTRL_RATE_LSB   4
`define CTRL_DIR_BIT    8
`define CTRL_SEL_LSB    9
`define CTRL_DRIVE_BIT  12
`define CTRL_AUTO_BIT   13
`define CTRL_SLEEP_BIT  14
`define CTRL_CONT_BIT   15
`define CTRL_START_BIT  16
`define CTRL_RST        32'h0000_0000
`define RANGE_RST       32'h03FF_0000

// Playback sources
`define MODE_DIRECT     2'h0
`define MODE_QUEUE      2'h1
`define MODE_RAMPLAY    2'h2
`define MODE_SYNTH      2'h3

// Flag bits
`define FLG_SENSE       0
`define FLG_DONE        1
`define FLG_DROP        2
`define FLG_STATE       3

// AXI responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// Timing
`define CLK_HZ          10000000
`define RATE_MAX_SPS    1024000
`define START_MAX_US    300
`define START_MAX_CYC   (`START_MAX_US * (`CLK_HZ / 1000000))
`define TRIG_MAX_US     30
`define TRIG_MAX_CYC    (`TRIG_MAX_US * (`CLK_HZ / 1000000))
`define WAKE_US         10
`define WAKE_CYC        (`WAKE_US * (`CLK_HZ / 1000000))
`define MID_SCALE       12'h800

`endif

// ===== hw/haptic_waveform_playback_ctrl.v
`timescale 1ns/10ps
`default_nettype none
`include "haptic_map.vh"

module haptic_waveform_playback_ctrl #(
    parameter AW    = 8,
    parameter DEPTH = 1024,
    parameter PW    = 10
) (
    input  wire          aclk,
    input  wire          aresetn,
    input  wire [AW-1:0] s_axi_awaddr,
    input  wire          s_axi_awvalid,
    output reg           s_axi_awready,
    input  wire [31:0]   s_axi_wdata,
    input  wire [3:0]    s_axi_wstrb,
    input  wire          s_axi_wvalid,
    output reg           s_axi_wready,
    output reg  [1:0]    s_axi_bresp,
    output reg           s_axi_bvalid,
    input  wire          s_axi_bready,
    input  wire [AW-1:0] s_axi_araddr,
    input  wire          s_axi_arvalid,
    output reg           s_axi_arready,
    output reg  [31:0]   s_axi_rdata,
    output reg  [1:0]    s_axi_rresp,
    output reg           s_axi_rvalid,
    input  wire          s_axi_rready,
    input  wire          sense_event,
    input  wire          gpio_in,
    output reg           gpio_out,
    output reg           gpio_oe,
    output reg  [11:0]   sample_out,
    output reg           sample_strobe,
    output reg           output_range,
    output reg           drive_enable,
    output reg           sleep_active
);

    localparam ST_IDLE  = 4'b0001;
    localparam ST_SLEEP = 4'b0010;
    localparam ST_WAKE  = 4'b0100;
    localparam ST_RUN   = 4'b1000;

    // Register index, 7 for unmapped
    function [2:0] reg_index;
        input [AW-1:0] a;
        begin
            case (a[7:0])
                `OFS_CTRL:       reg_index = 3'd0;
                `OFS_SAMPLE:     reg_index = 3'd1;
                `OFS_STATUS:     reg_index = 3'd2;
                `OFS_RAM_ADDR:   reg_index = 3'd3;
                `OFS_RAM_DATA:   reg_index = 3'd4;
                `OFS_PLAY_RANGE: reg_index = 3'd5;
                `OFS_FLAGS:      reg_index = 3'd6;
                default:         reg_index = 3'd7;
            endcase
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[8*i +: 8] = nw[8*i +: 8];
                end
            end
        end
    endfunction

    // Sample period in clocks, rounded to nearest
    function [10:0] rate_div;
        input [2:0] code;
        integer r;
        integer q;
        begin
            r = `RATE_MAX_SPS >> code;
            q = ((2 * `CLK_HZ / r) + 1) / 2;
            rate_div = q[10:0];
        end
    endfunction

    function [10:0] quarter;
        input [4:0] k;
        begin
            case (k)
                5'd0:  quarter = 11'd0;
                5'd1:  quarter = 11'd201;
                5'd2:  quarter = 11'd399;
                5'd3:  quarter = 11'd594;
                5'd4:  quarter = 11'd783;
                5'd5:  quarter = 11'd965;
                5'd6:  quarter = 11'd1137;
                5'd7:  quarter = 11'd1299;
                5'd8:  quarter = 11'd1447;
                5'd9:  quarter = 11'd1582;
                5'd10: quarter = 11'd1702;
                5'd11: quarter = 11'd1805;
                5'd12: quarter = 11'd1891;
                5'd13: quarter = 11'd1959;
                5'd14: quarter = 11'd2008;
                5'd15: quarter = 11'd2037;
                default: quarter = 11'd2047;
            endcase
        end
    endfunction

    // 64-step sine, signed 12 bits
    function signed [11:0] sine;
        input [5:0] p;
        reg [10:0] m;
        begin
            m = p[4] ? quarter(5'd16 - {1'b0, p[3:0]}) : quarter({1'b0, p[3:0]});
            sine = p[5] ? -$signed({1'b0, m}) : $signed({1'b0, m});
        end
    endfunction

    reg [15:0] mem [0:DEPTH-1];

    reg [31:0] ctrl_q;
    reg [31:0] range_q;
    reg [PW-1:0] ram_addr_q;
    reg [3:0]  flags_q;
    reg [11:0] direct_q;
    reg [PW-1:0] wr_ptr_q;
    reg [PW-1:0] rd_ptr_q;
    reg [PW:0] count_q;
    reg [PW-1:0] play_ptr_q;
    reg [15:0] phase_q;
    reg [15:0] dur_q;
    reg [15:0] step_q;
    reg [11:0] amp_q;
    reg [3:0]  state_q;
    reg [3:0]  state_prev_q;
    reg [11:0] wake_cnt_q;
    reg        pend_q;
    reg [10:0] div_q;
    reg        aw_full_q;
    reg        w_full_q;
    reg [AW-1:0] aw_addr_q;
    reg [31:0] wdata_q;
    reg [3:0]  wstrb_q;
    reg        gsync1_q;
    reg        gsync2_q;
    reg        gprev_q;

    wire [1:0] mode     = ctrl_q[`CTRL_MODE_LSB +: 2];
    wire       oe       = ctrl_q[`CTRL_OE_BIT];
    wire [2:0] rate     = ctrl_q[`CTRL_RATE_LSB +: 3];
    wire       pin_in   = ctrl_q[`CTRL_DIR_BIT];
    wire [2:0] pin_sel  = ctrl_q[`CTRL_SEL_LSB +: 3];
    wire       pin_pp   = ctrl_q[`CTRL_DRIVE_BIT];
    wire       auto_trg = ctrl_q[`CTRL_AUTO_BIT];
    wire       cont     = ctrl_q[`CTRL_CONT_BIT];
    wire [PW-1:0] start_addr = range_q[PW-1:0];
    wire [PW-1:0] end_addr   = range_q[16 +: PW];

    wire do_write = aw_full_q & w_full_q & ~s_axi_bvalid;
    wire [2:0] widx = reg_index(aw_addr_q);
    wire wr_sample = do_write & (widx == 3'd1) & (|wstrb_q);
    wire wr_ram    = do_write & (widx == 3'd4) & (|wstrb_q);
    wire q_full    = (count_q == DEPTH);
    wire q_push    = wr_sample & (mode == `MODE_QUEUE) & ~q_full;
    wire q_drop    = wr_sample & (mode == `MODE_QUEUE) & q_full;
    wire tick      = (div_q == 11'd0) & (state_q != ST_SLEEP);
    wire q_pop     = tick & oe & (mode == `MODE_QUEUE) & (count_q != 0);
    wire pin_fall  = pin_in & gprev_q & ~gsync2_q;
    wire start_cmd = do_write & (widx == 3'd0) & wstrb_q[2] & wdata_q[`CTRL_START_BIT];
    wire trig      = start_cmd | pin_fall | (sense_event & auto_trg);
    wire ram_mode  = mode[1];
    wire bus_touch = (s_axi_awvalid & s_axi_awready) | (s_axi_arvalid & s_axi_arready);

    wire [15:0] rec_amp  = mem[play_ptr_q];
    wire [15:0] rec_step = mem[play_ptr_q + 1'b1];
    wire [15:0] rec_dur  = mem[play_ptr_q + 2'd2];
    wire signed [24:0] prod = $signed({1'b0, amp_q}) * sine(phase_q[15:10]);
    wire [11:0] synth_smp = `MID_SCALE + prod[23:12];
    wire end_play = (play_ptr_q == end_addr);

    // Pin synchroniser, first stage feeds only the second
    always @(posedge aclk) begin
        if (!aresetn) begin
            gsync1_q <= 1'b1;
            gsync2_q <= 1'b1;
            gprev_q  <= 1'b1;
        end else begin
            gsync1_q <= gpio_in;
            gsync2_q <= gsync1_q;
            gprev_q  <= gsync2_q;
        end
    end

    // Memory shared by queue, playback and synthesis
    always @(posedge aclk) begin
        if (wr_ram) begin
            mem[ram_addr_q] <= wdata_q[15:0];
        end else if (q_push) begin
            mem[wr_ptr_q] <= {4'h0, wdata_q[11:0]};
        end
    end

    // Bus slave
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
            aw_full_q     <= 1'b0;
            w_full_q      <= 1'b0;
            aw_addr_q     <= {AW{1'b0}};
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_addr_q     <= s_axi_awaddr;
                aw_full_q     <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                w_full_q     <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (widx == 3'd7) ? `RESP_SLVERR : `RESP_OKAY;
            end
            if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_full_q     <= 1'b0;
                w_full_q      <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `RESP_OKAY;
                case (reg_index(s_axi_araddr))
                    3'd0: s_axi_rdata <= ctrl_q;
                    3'd1: s_axi_rdata <= {20'h0_0000, sample_out};
                    3'd2: s_axi_rdata <= {{(25-PW){1'b0}}, state_q, q_full,
                                          count_q == {(PW+1){1'b0}}, count_q};
                    3'd3: s_axi_rdata <= {{(32-PW){1'b0}}, ram_addr_q};
                    3'd4: s_axi_rdata <= {16'h0000, mem[ram_addr_q]};
                    3'd5: s_axi_rdata <= range_q;
                    3'd6: s_axi_rdata <= {28'h000_0000, flags_q};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Control registers; the start bit is a pulse and never stored
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q     <= `CTRL_RST;
            range_q    <= `RANGE_RST;
            ram_addr_q <= {PW{1'b0}};
            direct_q   <= `MID_SCALE;
        end else if (do_write) begin
            case (widx)
                3'd0: ctrl_q <= merge(ctrl_q, wdata_q & 32'h0000_FFFF, wstrb_q);
                3'd1: direct_q <= wdata_q[11:0];
                3'd3: ram_addr_q <= wdata_q[PW-1:0];
                3'd4: ram_addr_q <= ram_addr_q + 1'b1;
                3'd5: range_q <= merge(range_q, wdata_q, wstrb_q);
                default: ram_addr_q <= ram_addr_q;
            endcase
        end
    end

    // Queue pointers
    always @(posedge aclk) begin
        if (!aresetn || mode != `MODE_QUEUE) begin
            wr_ptr_q <= {PW{1'b0}};
            rd_ptr_q <= {PW{1'b0}};
            count_q  <= {(PW+1){1'b0}};
        end else begin
            if (q_push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (q_pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            count_q <= count_q + {{PW{1'b0}}, q_push} - {{PW{1'b0}}, q_pop};
        end
    end

    // Sample-rate divider
    always @(posedge aclk) begin
        if (!aresetn || div_q == 11'd0) begin
            div_q <= rate_div(rate) - 1'b1;
        end else begin
            div_q <= div_q - 1'b1;
        end
    end

    // Sleep, wake and RAM playback sequencing
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q    <= ST_IDLE;
            wake_cnt_q <= 12'h000;
            pend_q     <= 1'b0;
            play_ptr_q <= {PW{1'b0}};
            phase_q    <= 16'h0000;
            dur_q      <= 16'h0000;
            step_q     <= 16'h0000;
            amp_q      <= 12'h000;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    play_ptr_q <= start_addr;
                    dur_q      <= 16'h0000;
                    phase_q    <= 16'h0000;
                    if (trig & oe & ram_mode) begin
                        state_q <= ST_RUN;
                    end else if (ctrl_q[`CTRL_SLEEP_BIT] & ~oe) begin
                        state_q <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    wake_cnt_q <= 12'h000;
                    pend_q     <= trig;
                    if (bus_touch | trig) begin
                        state_q <= ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    // Wake time is well inside the start-up bound
                    wake_cnt_q <= wake_cnt_q + 1'b1;
                    pend_q     <= pend_q | trig;
                    if (wake_cnt_q == `WAKE_CYC - 1) begin
                        state_q <= (pend_q & oe & ram_mode) ? ST_RUN : ST_IDLE;
                    end
                end
                ST_RUN: begin
                    if (~oe | ~ram_mode) begin
                        state_q <= ST_IDLE;
                    end else if (tick && mode == `MODE_RAMPLAY) begin
                        play_ptr_q <= end_play ? start_addr : play_ptr_q + 1'b1;
                        if (end_play & ~cont) begin
                            state_q <= ST_IDLE;
                        end
                    end else if (tick && dur_q == 16'h0000) begin
                        // Record of amplitude, phase step, duration
                        amp_q   <= rec_amp[11:0];
                        step_q  <= rec_step;
                        dur_q   <= rec_dur;
                        phase_q <= 16'h0000;
                        play_ptr_q <= play_ptr_q + 2'd3;
                        if (rec_dur == 16'h0000 || end_play) begin
                            play_ptr_q <= start_addr;
                            state_q    <= cont ? ST_RUN : ST_IDLE;
                        end
                    end else if (tick) begin
                        phase_q <= phase_q + step_q;
                        dur_q   <= dur_q - 1'b1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Sticky flags, write one to clear, a new event wins over the clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            flags_q      <= 4'h0;
            state_prev_q <= ST_IDLE;
        end else begin
            state_prev_q <= state_q;
            flags_q <= (flags_q & ~((do_write && widx == 3'd6) ? wdata_q[3:0] : 4'h0))
                       | {state_q != state_prev_q,
                          q_drop,
                          state_q == ST_RUN && state_prev_q == ST_RUN && !ram_mode,
                          sense_event};
            if (state_prev_q == ST_RUN && state_q == ST_IDLE) begin
                flags_q[`FLG_DONE] <= 1'b1;
            end
        end
    end

    // Output sample stage
    always @(posedge aclk) begin
        if (!aresetn) begin
            sample_out    <= `MID_SCALE;
            sample_strobe <= 1'b0;
            output_range  <= 1'b0;
            drive_enable  <= 1'b0;
            sleep_active  <= 1'b0;
        end else begin
            sample_strobe <= 1'b0;
            output_range  <= ctrl_q[`CTRL_RANGE_BIT];
            drive_enable  <= oe & (state_q != ST_SLEEP);
            sleep_active  <= (state_q == ST_SLEEP);
            if (tick & oe) begin
                case (mode)
                    `MODE_DIRECT: begin
                        sample_out    <= direct_q;
                        sample_strobe <= 1'b1;
                    end
                    `MODE_QUEUE: if (q_pop) begin
                        sample_out    <= mem[rd_ptr_q][11:0];
                        sample_strobe <= 1'b1;
                    end
                    `MODE_RAMPLAY: if (state_q == ST_RUN) begin
                        sample_out    <= mem[play_ptr_q][11:0];
                        sample_strobe <= 1'b1;
                    end
                    default: if (state_q == ST_RUN && dur_q != 16'h0000) begin
                        sample_out    <= synth_smp;
                        sample_strobe <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Event pin, active low
    reg pin_act;
    always @* begin
        case (pin_sel)
            3'd0:    pin_act = flags_q[`FLG_SENSE];
            3'd1:    pin_act = flags_q[`FLG_DONE];
            3'd2:    pin_act = flags_q[`FLG_DROP];
            3'd3:    pin_act = (count_q == 0) & (mode == `MODE_QUEUE);
            3'd4:    pin_act = flags_q[`FLG_STATE];
            3'd5:    pin_act = (state_q == ST_RUN);
            default: pin_act = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            gpio_out <= 1'b1;
            gpio_oe  <= 1'b0;
        end else if (pin_in) begin
            gpio_out <= 1'b1;
            gpio_oe  <= 1'b0;
        end else if (pin_pp) begin
            gpio_out <= ~pin_act;
            gpio_oe  <= 1'b1;
        end else begin
            gpio_out <= 1'b0;
            gpio_oe  <= pin_act;
        end
    end

endmodule // haptic_waveform_playback_ctrl

`default_nettype wire

// ===== verif/pin_partner.sv
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
    input  wire logic gpio_out,
    input  wire logic gpio_oe,
    input  wire logic pull_low,
    output wire logic pin_level
);
    // Board pull-up wins when nobody drives the line
    assign pin_level = pull_low ? 1'b0 : (gpio_oe ? gpio_out : 1'b1);
endmodule // pin_partner
`default_nettype wire

// ===== verif/playback_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module playback_asserts #(parameter AW = 8) (
    input wire logic          aclk,
    input wire logic          aresetn,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic          s_axi_awvalid,
    input wire logic          s_axi_awready,
    input wire logic          s_axi_wvalid,
    input wire logic          s_axi_wready,
    input wire logic [1:0]    s_axi_bresp,
    input wire logic          s_axi_bvalid,
    input wire logic          s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic          s_axi_arvalid,
    input wire logic          s_axi_arready,
    input wire logic [31:0]   s_axi_rdata,
    input wire logic [1:0]    s_axi_rresp,
    input wire logic          s_axi_rvalid,
    input wire logic          sample_strobe,
    input wire logic [11:0]   sample_out,
    input wire logic          drive_enable,
    input wire logic          sleep_active
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire rd_go = s_axi_arvalid && s_axi_arready;
    a_write_answer: assert property (wr_go |-> ##2 s_axi_bvalid)
        else $error("no write response");
    a_read_answer: assert property (rd_go |=> s_axi_rvalid) else $error("no read response");
    a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_unmapped_rd: assert property (rd_go && s_axi_araddr > 8'h18 |=>
        s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000) else $error("bad unmapped read");
    a_unmapped_wr: assert property (wr_go && s_axi_awaddr > 8'h18 |->
        ##2 s_axi_bresp == 2'h2) else $error("bad unmapped write");
    a_strobe_space: assert property (sample_strobe |=> !sample_strobe [*8])
        else $error("strobes too close");
    a_sample_stands: assert property (!$stable(sample_out) |-> sample_strobe)
        else $error("sample changed without strobe");
    a_strobe_enabled: assert property (sample_strobe |-> drive_enable || $past(drive_enable))
        else $error("strobe while disabled");
    a_sleep_quiet: assert property (sleep_active |-> !drive_enable)
        else $error("drive while asleep");
    c_strobe: cover property (sample_strobe);
    c_sleep: cover property (sleep_active);
    c_unmapped: cover property (rd_go && s_axi_araddr > 8'h18);
endmodule // playback_asserts
bind haptic_waveform_playback_ctrl playback_asserts #(.AW(AW)) u_playback_asserts (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .sample_strobe(sample_strobe),
    .sample_out(sample_out), .drive_enable(drive_enable), .sleep_active(sleep_active));
`default_nettype wire

// ===== verif/test_haptic_waveform_playback_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "haptic_map.vh"
module test_haptic_waveform_playback_ctrl;
    logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic        sense = 0, pull_low = 0;
    logic [7:0]  awa = 0, ara = 0;
    logic [31:0] wd = 0, d;
    logic [1:0]  r;
    wire         awr, wrd, bv, arr, rv, g_out, g_oe, pin, stb, rng, den, slp;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [11:0] so;
    integer      err_total = 0, check_count = 0, cyc = 0, c;
    haptic_waveform_playback_ctrl u_haptic_waveform_playback_ctrl (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .sense_event(sense),
        .gpio_in(pin), .gpio_out(g_out), .gpio_oe(g_oe), .sample_out(so),
        .sample_strobe(stb), .output_range(rng), .drive_enable(den), .sleep_active(slp));
    pin_partner u_pin_partner (.gpio_out(g_out), .gpio_oe(g_oe), .pull_low(pull_low),
        .pin_level(pin));
    initial forever #50 aclk = ~aclk;
    task summarize;
        if (err_total == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_total = err_total + 1;
            summarize;
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awa <= a; wd <= v; awv <= 1; wv <= 1; br <= 1;
        do begin
            @(posedge aclk);
            if (awr === 1'b1) awv <= 0;
            if (wrd === 1'b1) wv <= 0;
        end while (bv !== 1'b1);
        r = bresp;
        br <= 0;
        // Registered outputs settle before anyone looks
        @(negedge aclk);
    endtask
    task rd(input logic [7:0] a);
        @(posedge aclk);
        ara <= a; arv <= 1; rr <= 1;
        do begin
            @(posedge aclk);
            if (arr === 1'b1) arv <= 0;
        end while (rv !== 1'b1);
        d = rdata; r = rresp;
        rr <= 0;
        @(negedge aclk);
    endtask
    // Returns cycles waited; equals lim when no strobe came
    task ws(input integer lim);
        c = 0;
        do begin
            @(posedge aclk);
            c = c + 1;
        end while (stb !== 1'b1 && c < lim);
    endtask
    task t_bus;
        chk(g_oe, 0); chk(g_out, 1); chk(so, 12'h800);
        rd(8'h1C); chk(r, 2); chk(d, 0);
        wr(8'h1C, 32'h0000_0001); chk(r, 2);
    endtask
    task t_direct;
        wr(8'h00, 32'h0000_000C); chk(rng, 1);
        chk(den, 1);
        wr(8'h04, 32'h0000_F123); ws(20); chk(so, 12'h123);
    endtask
    task t_queue(input logic [2:0] rate, input integer per);
        wr(8'h00, {25'h0, rate, 4'h1}); chk(rng, 0);
        wr(8'h04, 32'h0000_0111); wr(8'h04, 32'h0000_0222); wr(8'h04, 32'h0000_0333);
        rd(8'h08); chk(d[11:0], 12'h003);
        wr(8'h00, {25'h0, rate, 4'h5});
        ws(per + 5); chk(so, 12'h111);
        ws(per + 5); chk(so, 12'h222); chk(c, per);
        ws(per + 5); chk(so, 12'h333); chk(c, per);
        ws(per + 5); chk(c, per + 5); chk(so, 12'h333);
        rd(8'h08); chk(d[11], 1);
    endtask
    task t_full;
        wr(8'h00, 32'h0000_0001);
        repeat (1025) wr(8'h04, 32'h0000_0555);
        rd(8'h08); chk(d[12:0], 13'h1400);
        rd(8'h18); chk(d[2], 1);
    endtask
    task t_pin;
        wr(8'h00, 32'h0000_0000); wr(8'h00, 32'h0000_0601); repeat (3) @(posedge aclk);
        chk({g_oe, g_out, pin}, 3'b100);
        wr(8'h00, 32'h0000_1E01); repeat (3) @(posedge aclk); chk({g_oe, g_out}, 2'b11);
        wr(8'h00, 32'h0000_0E01); repeat (3) @(posedge aclk); chk({g_oe, pin}, 2'b01);
    endtask
    task t_trig;
        wr(8'h0C, 0); wr(8'h10, 32'h0000_0456); wr(8'h14, 0);
        wr(8'h00, 32'h0000_0106);
        @(posedge aclk) pull_low <= 1;
        ws(30); chk(so, 12'h456);
        @(posedge aclk) pull_low <= 0;
        wr(8'h0C, 0); wr(8'h10, 32'h0000_0789); wr(8'h00, 32'h0000_2106);
        @(posedge aclk) sense <= 1;
        @(posedge aclk) sense <= 0;
        ws(`TRIG_MAX_CYC); chk(so, 12'h789);
        wr(8'h00, 32'h0000_4002); repeat (5) @(posedge aclk); chk(slp, 1);
        chk(den, 0);
        wr(8'h00, 32'h0001_0006); wr(8'h00, 32'h0001_0006);
        ws(`START_MAX_CYC); chk(c < `START_MAX_CYC, 1);
    endtask
    // One record: half scale amplitude, quarter turn per sample, two samples
    task t_synth;
        wr(8'h0C, 0); wr(8'h10, 32'h0000_0800); wr(8'h10, 32'h0000_4000); wr(8'h10, 2);
        wr(8'h14, 32'h0003_0000); wr(8'h00, 32'h0001_0007);
        ws(30); chk(so, 12'h800);
        ws(15); chk(so, 12'hBFF); chk(c, 10);
        ws(25); chk(c, 25);
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        t_bus; t_direct; t_queue(3'h0, 10); t_queue(3'h7, 1250); t_full; t_pin; t_trig;
        t_synth;
        summarize;
    end
endmodule // test_haptic_waveform_playback_ctrl
`default_nettype wire
